// ### hdl/tcb_pkg.sv
// constants, field layouts and enumerations of the timer and counter bank
`default_nettype none
package tcb_pkg;
   // ----------------------------------------------------------------
   // clock and time base
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS     = 8;
   localparam int unsigned HUNDREDTH_TICK_NS = 10000;
   localparam int unsigned TENTH_TICK_NS     = 100000;
   localparam int unsigned ACCUM_TICK_MS     = 100;
   localparam int unsigned NS_PER_MS         = 1000000;
   localparam int unsigned HUNDREDTH_TICK_CYC = HUNDREDTH_TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned TENTH_TICK_CYC     = TENTH_TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned ACCUM_TICK_CYC     = ACCUM_TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned PRE_W              = 32;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int unsigned NUM_TIMERS_DEF   = 4096;
   localparam int unsigned NUM_COUNTERS_DEF = 4096;
   localparam int unsigned VAL_W_DEF        = 16;
   localparam int unsigned APB_AW           = 8;
   localparam int unsigned APB_DW           = 32;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [APB_AW-1:0] ADDR_CMD      = 8'h00;
   localparam logic [APB_AW-1:0] ADDR_SETVAL   = 8'h04;
   localparam logic [APB_AW-1:0] ADDR_SEL      = 8'h08;
   localparam logic [APB_AW-1:0] ADDR_TIM_STAT = 8'h0C;
   localparam logic [APB_AW-1:0] ADDR_CNT_STAT = 8'h10;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned CMD_OP_LSB    = 0;
   localparam int unsigned OP_W          = 3;
   localparam int unsigned CMD_EXEC_BIT  = 8;
   localparam int unsigned CMD_RST_BIT   = 9;
   localparam int unsigned CMD_INC_BIT   = 10;
   localparam int unsigned CMD_DEC_BIT   = 11;
   localparam int unsigned CMD_CH_LSB    = 16;
   localparam int unsigned SEL_TIM_LSB   = 0;
   localparam int unsigned SEL_CNT_LSB   = 16;
   localparam logic [3:0]  STRB_FULL     = 4'hF;
   localparam logic [APB_DW-1:0] RD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // instruction codes and per-channel timer modes
   // ----------------------------------------------------------------
   typedef enum logic [OP_W-1:0] {
      OP_NONE        = 3'h0,
      OP_TENTH       = 3'h1,
      OP_ACCUM       = 3'h2,
      OP_HUNDREDTH   = 3'h3,
      OP_TIMER_RESET = 3'h5,
      OP_DOWN_CNT    = 3'h6,
      OP_UPDOWN_CNT  = 3'h7
   } tcb_op_e;

   typedef enum logic [1:0] {
      TM_IDLE      = 2'h0,
      TM_TENTH     = 2'h1,
      TM_HUNDREDTH = 2'h3,
      TM_ACCUM     = 2'h2
   } tcb_tmode_e;
endpackage : tcb_pkg
`default_nettype wire

// ### hdl/tcb_timer_counter_bank.sv
// timer and counter bank with its apb register slave
//
// Local design decisions: the APB slave port and the address map.
`default_nettype none
module tcb_timer_counter_bank
   import tcb_pkg::*;
#(
   parameter int unsigned NUM_TIMERS     = tcb_pkg::NUM_TIMERS_DEF,
   parameter int unsigned NUM_COUNTERS   = tcb_pkg::NUM_COUNTERS_DEF,
   parameter int unsigned VAL_W          = tcb_pkg::VAL_W_DEF,
   parameter int unsigned HUNDREDTH_CYC  = tcb_pkg::HUNDREDTH_TICK_CYC,
   parameter int unsigned TENTH_CYC      = tcb_pkg::TENTH_TICK_CYC,
   parameter int unsigned ACCUM_CYC      = tcb_pkg::ACCUM_TICK_CYC
) (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [tcb_pkg::APB_AW-1:0]  paddr,
   input  wire logic [tcb_pkg::APB_DW-1:0]  pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [tcb_pkg::APB_DW-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr
);
   import tcb_pkg::*;

   localparam int unsigned TCH_W = $clog2(NUM_TIMERS);
   localparam int unsigned CCH_W = $clog2(NUM_COUNTERS);
   localparam logic [VAL_W-1:0] VAL_ZERO = '0;
   localparam logic [VAL_W-1:0] VAL_ONE  = VAL_W'(1);
   localparam int unsigned RD_PAD = APB_DW - VAL_W - 1;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       [NUM_TIMERS-1:0][VAL_W-1:0]   tpv;
      logic       [NUM_TIMERS-1:0][VAL_W-1:0]   tsv;
      logic       [NUM_TIMERS-1:0]              tdone;
      logic       [NUM_TIMERS-1:0]              texec;
      logic       [NUM_TIMERS-1:0]              trun;
      tcb_tmode_e [NUM_TIMERS-1:0]              tmode;
      logic       [NUM_COUNTERS-1:0][VAL_W-1:0] cpv;
      logic       [NUM_COUNTERS-1:0]            cdone;
      logic       [NUM_COUNTERS-1:0]            cprev_a;
      logic       [NUM_COUNTERS-1:0]            cprev_b;
      logic       [VAL_W-1:0]                   setval;
      logic       [TCH_W-1:0]                   tsel;
      logic       [CCH_W-1:0]                   csel;
      logic       [PRE_W-1:0]                   pre_h;
      logic       [PRE_W-1:0]                   pre_t;
      logic       [PRE_W-1:0]                   pre_a;
      logic       [APB_DW-1:0]                  rdata;
      logic                                     err;
   } tcb_state_s;

   tcb_state_s q;
   tcb_state_s d;

   logic              tick_h;
   logic              tick_t;
   logic              tick_a;
   logic              acc_wr;
   logic              cmd_fire;
   tcb_op_e           op;
   logic [TCH_W-1:0]  tch;
   logic [CCH_W-1:0]  cch;
   logic              c_exec;
   logic              c_rst;
   logic              c_inc;
   logic              c_dec;
   logic              rise_a;
   logic              rise_b;
   logic              rd_ok;
   logic              wr_ok;

   // ----------------------------------------------------------------
   // apb outputs
   // ----------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = psel & penable & q.err;
   assign prdata  = q.rdata;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   assign acc_wr   = psel & penable & pwrite & ~q.err;
   assign cmd_fire = acc_wr & (paddr == ADDR_CMD);
   assign op       = tcb_op_e'(pwdata[CMD_OP_LSB +: OP_W]);
   assign tch      = pwdata[CMD_CH_LSB +: TCH_W];
   assign cch      = pwdata[CMD_CH_LSB +: CCH_W];
   assign c_exec   = pwdata[CMD_EXEC_BIT];
   assign c_rst    = pwdata[CMD_RST_BIT];
   assign c_inc    = pwdata[CMD_INC_BIT];
   assign c_dec    = pwdata[CMD_DEC_BIT];
   assign rise_a   = c_inc & ~q.cprev_a[cch];
   assign rise_b   = c_dec & ~q.cprev_b[cch];

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;

      // free-running time base
      tick_h = (q.pre_h == PRE_W'(HUNDREDTH_CYC - 1));
      tick_t = (q.pre_t == PRE_W'(TENTH_CYC - 1));
      tick_a = (q.pre_a == PRE_W'(ACCUM_CYC - 1));
      d.pre_h = tick_h ? '0 : q.pre_h + 1'b1;
      d.pre_t = tick_t ? '0 : q.pre_t + 1'b1;
      d.pre_a = tick_a ? '0 : q.pre_a + 1'b1;

      // autonomous timing of every running timer channel
      for (int i = 0; i < NUM_TIMERS; i++) begin
         case (q.tmode[i])
            TM_TENTH, TM_HUNDREDTH: begin
               if (q.trun[i] && q.tpv[i] != VAL_ZERO &&
                   ((q.tmode[i] == TM_TENTH && tick_t) || (q.tmode[i] == TM_HUNDREDTH && tick_h))) begin
                  d.tpv[i]   = q.tpv[i] - 1'b1;
                  d.tdone[i] = (q.tpv[i] == VAL_ONE);
               end
            end
            TM_ACCUM: begin
               if (q.trun[i] && tick_a && !q.tdone[i]) begin
                  if (q.tpv[i] >= q.tsv[i]) begin
                     d.tdone[i] = 1'b1;
                  end else begin
                     d.tpv[i]   = q.tpv[i] + 1'b1;
                     d.tdone[i] = ((q.tpv[i] + 1'b1) == q.tsv[i]);
                  end
               end
            end
            default: ;
         endcase
      end

      // one evaluation of an instruction from the program
      if (cmd_fire && pstrb == STRB_FULL) begin
         case (op)
            OP_TENTH, OP_HUNDREDTH: begin
               d.tmode[tch] = (op == OP_TENTH) ? TM_TENTH : TM_HUNDREDTH;
               d.texec[tch] = c_exec;
               if (!c_exec) begin
                  d.tpv[tch]   = q.setval;
                  d.tdone[tch] = 1'b0;
                  d.trun[tch]  = 1'b0;
               end else if (!q.texec[tch]) begin
                  d.tpv[tch]   = q.setval;
                  d.tdone[tch] = (q.setval == VAL_ZERO);
                  d.trun[tch]  = 1'b1;
               end
            end
            OP_ACCUM: begin
               d.tmode[tch] = TM_ACCUM;
               d.tsv[tch]   = q.setval;
               d.texec[tch] = c_exec;
               if (c_rst) begin
                  d.tpv[tch]   = VAL_ZERO;
                  d.tdone[tch] = 1'b0;
                  d.trun[tch]  = 1'b0;
               end else begin
                  d.trun[tch] = c_exec;
                  if (d.tpv[tch] >= q.setval) begin
                     d.tdone[tch] = 1'b1;
                  end
               end
            end
            OP_TIMER_RESET: begin
               if (c_exec) begin
                  d.tpv[tch]   = VAL_ZERO;
                  d.tdone[tch] = 1'b0;
                  d.trun[tch]  = 1'b0;
                  d.texec[tch] = 1'b0;
                  d.tmode[tch] = TM_IDLE;
               end
            end
            OP_DOWN_CNT: begin
               d.cprev_a[cch] = c_inc;
               if (c_rst) begin
                  d.cpv[cch]   = q.setval;
                  d.cdone[cch] = 1'b0;
               end else if (rise_a && q.cpv[cch] != VAL_ZERO) begin
                  d.cpv[cch]   = q.cpv[cch] - 1'b1;
                  d.cdone[cch] = (q.cpv[cch] == VAL_ONE);
               end else if (q.cpv[cch] == VAL_ZERO) begin
                  d.cdone[cch] = 1'b1;
               end
            end
            OP_UPDOWN_CNT: begin
               d.cprev_a[cch] = c_inc;
               d.cprev_b[cch] = c_dec;
               if (c_rst) begin
                  d.cpv[cch]   = VAL_ZERO;
                  d.cdone[cch] = 1'b0;
               end else if (rise_a && !rise_b) begin
                  if (q.cpv[cch] >= q.setval) begin
                     d.cpv[cch]   = VAL_ZERO;
                     d.cdone[cch] = 1'b1;
                  end else begin
                     d.cpv[cch]   = q.cpv[cch] + 1'b1;
                     d.cdone[cch] = 1'b0;
                  end
               end else if (rise_b && !rise_a) begin
                  if (q.cpv[cch] == VAL_ZERO) begin
                     d.cpv[cch]   = q.setval;
                     d.cdone[cch] = 1'b1;
                  end else begin
                     d.cpv[cch]   = q.cpv[cch] - 1'b1;
                     d.cdone[cch] = 1'b0;
                  end
               end
               // both rising together: value kept
            end
            default: ;
         endcase
      end

      // plain register writes
      if (acc_wr && paddr == ADDR_SETVAL) begin
         d.setval = pwdata[VAL_W-1:0];
      end
      if (acc_wr && paddr == ADDR_SEL) begin
         d.tsel = pwdata[SEL_TIM_LSB +: TCH_W];
         d.csel = pwdata[SEL_CNT_LSB +: CCH_W];
      end

      // setup phase: decode, check and capture read data
      rd_ok = 1'b1;
      wr_ok = 1'b0;
      if (psel && !penable) begin
         d.rdata = RD_ZERO;
         case (paddr)
            ADDR_CMD: wr_ok = 1'b1;
            ADDR_SETVAL: begin
               wr_ok   = 1'b1;
               d.rdata = {{(APB_DW-VAL_W){1'b0}}, q.setval};
            end
            ADDR_SEL: begin
               wr_ok   = 1'b1;
               d.rdata[SEL_TIM_LSB +: TCH_W] = q.tsel;
               d.rdata[SEL_CNT_LSB +: CCH_W] = q.csel;
            end
            ADDR_TIM_STAT: d.rdata = {{RD_PAD{1'b0}}, q.tdone[q.tsel], q.tpv[q.tsel]};
            ADDR_CNT_STAT: d.rdata = {{RD_PAD{1'b0}}, q.cdone[q.csel], q.cpv[q.csel]};
            default: rd_ok = 1'b0;
         endcase
         d.err = pwrite ? !(wr_ok && pstrb == STRB_FULL) : !rd_ok;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic quiet;
   assign quiet = ~(psel & penable & pwrite);

   AST_DOWN_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && (op == OP_TENTH || op == OP_HUNDREDTH) && c_exec && !q.texec[tch]
      |=> q.tpv[$past(tch)] == $past(q.setval) && q.trun[$past(tch)] && q.texec[$past(tch)])
      else $error("down timer not loaded on rising execution");

   AST_FALSE_COPY: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && (op == OP_TENTH || op == OP_HUNDREDTH) && !c_exec
      |=> q.tpv[$past(tch)] == $past(q.setval) && !q.tdone[$past(tch)] && !q.trun[$past(tch)])
      else $error("false execution did not copy set value");

   AST_DONE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (q.tmode[q.tsel] == TM_TENTH || q.tmode[q.tsel] == TM_HUNDREDTH) && q.trun[q.tsel]
      |-> q.tdone[q.tsel] == (q.tpv[q.tsel] == VAL_ZERO))
      else $error("down timer flag disagrees with zero value");

   AST_HOLD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      quiet && q.tmode[q.tsel] != TM_ACCUM && q.tpv[q.tsel] == VAL_ZERO ##1 quiet
      |-> q.tpv[q.tsel] == VAL_ZERO [*2])
      else $error("down timer left zero on its own");

   AST_ACC_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_ACCUM && c_rst
      |=> q.tpv[$past(tch)] == VAL_ZERO && !q.tdone[$past(tch)])
      else $error("accumulating reset did not clear");

   AST_ACC_HELD: assert property (@(posedge pclk) disable iff (!presetn)
      quiet && q.tmode[q.tsel] == TM_ACCUM && q.tdone[q.tsel]
      |=> $stable(q.tpv[q.tsel]) && q.tdone[q.tsel])
      else $error("timed-out accumulating timer changed");

   AST_DC_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_DOWN_CNT && c_rst
      |=> q.cpv[$past(cch)] == $past(q.setval) && !q.cdone[$past(cch)])
      else $error("down counter reset did not reload");

   AST_UD_UP_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_UPDOWN_CNT && !c_rst && rise_a && !rise_b
      && q.cpv[cch] == q.setval
      |=> q.cpv[$past(cch)] == VAL_ZERO && q.cdone[$past(cch)])
      else $error("up/down counter did not wrap to zero");

   AST_UD_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_UPDOWN_CNT && !c_rst && rise_a && rise_b
      |=> q.cpv[$past(cch)] == $past(q.cpv[cch]))
      else $error("simultaneous rises changed the counter");

   AST_TIMER_RESET_COMMAND: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_TIMER_RESET && c_exec
      |=> q.tpv[$past(tch)] == VAL_ZERO && !q.tdone[$past(tch)] && !q.trun[$past(tch)])
      else $error("timer reset command had no effect");

   AST_DC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_DOWN_CNT && !c_rst && rise_a && q.cpv[cch] != VAL_ZERO
      |=> q.cpv[$past(cch)] == $past(q.cpv[cch]) - VAL_ONE)
      else $error("down counter did not step on count rise");

   AST_DC_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_DOWN_CNT && !c_rst && q.cpv[cch] == VAL_ZERO
      |=> q.cpv[$past(cch)] == VAL_ZERO && q.cdone[$past(cch)])
      else $error("down counter left zero or lost its flag");

   AST_UD_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_UPDOWN_CNT && !c_rst && rise_a && !rise_b
      && q.cpv[cch] < q.setval
      |=> q.cpv[$past(cch)] == $past(q.cpv[cch]) + VAL_ONE && !q.cdone[$past(cch)])
      else $error("up/down counter did not step up");

   AST_UD_DN_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_UPDOWN_CNT && !c_rst && rise_b && !rise_a
      && q.cpv[cch] == VAL_ZERO
      |=> q.cpv[$past(cch)] == $past(q.setval) && q.cdone[$past(cch)])
      else $error("up/down counter did not wrap to set value");

   AST_UD_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && pstrb == STRB_FULL && op == OP_UPDOWN_CNT && c_rst
      |=> q.cpv[$past(cch)] == VAL_ZERO && !q.cdone[$past(cch)])
      else $error("up/down reset did not clear");

   AST_ACC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      quiet && tick_a && q.tmode[q.tsel] == TM_ACCUM && q.trun[q.tsel] && !q.tdone[q.tsel]
      && q.tpv[q.tsel] < q.tsv[q.tsel]
      |=> q.tpv[q.tsel] == $past(q.tpv[q.tsel]) + VAL_ONE)
      else $error("accumulating timer missed a tick");

   AST_ACC_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
      quiet && q.tmode[q.tsel] == TM_ACCUM && !q.trun[q.tsel]
      |=> $stable(q.tpv[q.tsel]))
      else $error("stopped accumulating timer changed");

   AST_ACC_STOP: assert property (@(posedge pclk) disable iff (!presetn)
      quiet && q.tmode[q.tsel] == TM_ACCUM && q.tpv[q.tsel] >= q.tsv[q.tsel]
      |=> $stable(q.tpv[q.tsel]))
      else $error("accumulating timer counted past set value");

endmodule : tcb_timer_counter_bank
`default_nettype wire

// ### dv/tcb_ctl_model.sv
// controller program model: apb master that issues the program's transfers
`default_nettype none
module tcb_ctl_model
   import tcb_pkg::*;
(
   // clock
   input  wire logic                       pclk,
   // apb master side
   output logic                            psel,
   output logic                            penable,
   output logic                            pwrite,
   output logic      [tcb_pkg::APB_AW-1:0] paddr,
   output logic      [tcb_pkg::APB_DW-1:0] pwdata,
   output logic      [3:0]                 pstrb,
   input  wire logic [tcb_pkg::APB_DW-1:0] prdata,
   input  wire logic                       pready,
   input  wire logic                       pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   int hangs;

   initial begin
      hangs = 0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
   end

   // ----------------------------------------------------------------
   // one transfer; each call is one short evaluation of the program
   // ----------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) hangs++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines stop showing the old request
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask : xfer
endmodule : tcb_ctl_model
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench of the timer and counter bank
`default_nettype none
module testbench
   import tcb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned HC = 5;
   localparam int unsigned TC = 10;
   localparam int unsigned AC = 20;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, v, p;
   logic [3:0]  pstrb;
   logic        e;
   int          num_errors = 0;
   int          check_count = 0;
   logic [1:0]  ud_in [8] = '{2'b01, 2'b01, 2'b01, 2'b01, 2'b10, 2'b10, 2'b10, 2'b11};
   logic [15:0] ud_pv [8] = '{16'h1, 16'h2, 16'h0, 16'h1, 16'h0, 16'h2, 16'h1, 16'h1};
   logic [7:0]  ud_f = 8'b0010_0100;

   always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

   tcb_timer_counter_bank #(.NUM_TIMERS(16), .NUM_COUNTERS(16), .VAL_W(16), .HUNDREDTH_CYC(HC),
      .TENTH_CYC(TC), .ACCUM_CYC(AC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   tcb_ctl_model ctl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // ----------------------------------------------------------------
   // access and compare helpers
   // ----------------------------------------------------------------
   task automatic w(input int n);
      repeat (n) @(posedge pclk);
   endtask : w

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        x;
      ctl.xfer(1'b1, a, d, STRB_FULL, r, x);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic x);
      ctl.xfer(1'b0, a, 32'h0000_0000, STRB_FULL, r, x);
   endtask : rd

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask : chk

   // b is {dec, inc, reset, exec}
   task automatic cmd(input logic [2:0] op, input logic [3:0] b, input logic [11:0] ch);
      wr(ADDR_CMD, {4'h0, ch, 4'h0, b, 5'h00, op});
   endtask : cmd

   task automatic st(input logic c, input logic [11:0] ch, output logic [31:0] r);
      logic x;
      wr(ADDR_SEL, {4'h0, ch, 4'h0, ch});
      rd(c ? ADDR_CNT_STAT : ADDR_TIM_STAT, r, x);
   endtask : st

   task automatic cs(input string nm, input logic c, input logic [11:0] ch, input logic [15:0] pv, input logic f);
      logic [31:0] r;
      st(c, ch, r);
      chk(nm, {15'h0000, f, pv}, r);
   endtask : cs

   task automatic rng(input string nm, input logic [11:0] ch, input logic [15:0] lo, input logic [15:0] hi);
      logic [31:0] r;
      st(1'b0, ch, r);
      check_count++;
      if (r[16] !== 1'b0 || (r[15:0] >= lo && r[15:0] <= hi) !== 1'b1) begin
         $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, r);
         num_errors++;
      end
   endtask : rng

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   initial begin
      #(100000 * CLK_PERIOD_NS);
      num_errors++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      w(20);
      presetn <= 1'b1;
      rd(ADDR_SETVAL, v, e);
      chk("setval reset", 32'h0000_0000, v);
      cs("timer reset state", 1'b0, 12'h000, 16'h0000, 1'b0);
      wr(ADDR_SETVAL, 32'h1234_FFFF);
      rd(ADDR_SETVAL, v, e);
      chk("setval width", 32'h0000_FFFF, v);
      rd(8'h20, v, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", RD_ZERO, v);
      ctl.xfer(1'b1, ADDR_TIM_STAT, 32'h0000_0001, STRB_FULL, v, e);
      chk("status write err", 32'h1, {31'h0, e});
      ctl.xfer(1'b1, ADDR_SETVAL, 32'h0000_0005, 4'h3, v, e);
      chk("strobe err", 32'h1, {31'h0, e});
      rd(ADDR_SETVAL, v, e);
      chk("strobe no effect", 32'h0000_FFFF, v);
      // down timers, tenth on 2 and hundredth on 3
      wr(ADDR_SETVAL, 32'h0000_0008);
      cmd(OP_TENTH, 4'b0001, 12'h002);
      rng("tenth load", 12'h002, 16'h7, 16'h8);
      cmd(OP_HUNDREDTH, 4'b0001, 12'h003);
      w(4 * TC);
      rng("tenth run", 12'h002, 16'h2, 16'h3);
      cs("hundredth done", 1'b0, 12'h003, 16'h0000, 1'b1);
      w(6 * TC);
      cs("tenth done hold", 1'b0, 12'h002, 16'h0000, 1'b1);
      cmd(OP_TENTH, 4'b0000, 12'h002);
      cs("tenth idle reload", 1'b0, 12'h002, 16'h0008, 1'b0);
      cmd(OP_TIMER_RESET, 4'b0001, 12'h003);
      cs("timer reset cmd", 1'b0, 12'h003, 16'h0000, 1'b0);
      cs("other channel kept", 1'b0, 12'h002, 16'h0008, 1'b0);
      // accumulating timer on 4
      wr(ADDR_SETVAL, 32'h0000_0003);
      cmd(OP_ACCUM, 4'b0001, 12'h004);
      w(AC + AC / 2);
      rng("accum run", 12'h004, 16'h1, 16'h2);
      cmd(OP_ACCUM, 4'b0000, 12'h004);
      st(1'b0, 12'h004, p);
      w(3 * AC);
      st(1'b0, 12'h004, v);
      chk("accum frozen", p, v);
      cmd(OP_ACCUM, 4'b0001, 12'h004);
      w(5 * AC);
      cs("accum done", 1'b0, 12'h004, 16'h0003, 1'b1);
      w(3 * AC);
      cs("accum held", 1'b0, 12'h004, 16'h0003, 1'b1);
      cmd(OP_ACCUM, 4'b0010, 12'h004);
      cs("accum reset", 1'b0, 12'h004, 16'h0000, 1'b0);
      // down counter on 1, set value 2
      wr(ADDR_SETVAL, 32'h0000_0002);
      cmd(OP_DOWN_CNT, 4'b0010, 12'h001);
      cs("down cnt reset", 1'b1, 12'h001, 16'h0002, 1'b0);
      for (int i = 0; i < 3; i++) begin
         cmd(OP_DOWN_CNT, 4'b0000, 12'h001);
         cmd(OP_DOWN_CNT, 4'b0100, 12'h001);
         cmd(OP_DOWN_CNT, 4'b0100, 12'h001);
         cs("down cnt step", 1'b1, 12'h001, (i == 0) ? 16'h1 : 16'h0, i != 0);
      end
      cmd(OP_DOWN_CNT, 4'b0000, 12'h001);
      cmd(OP_DOWN_CNT, 4'b0110, 12'h001);
      cs("down cnt reset count", 1'b1, 12'h001, 16'h0002, 1'b0);
      // up/down counter on 5, set value 2
      for (int i = 0; i < 8; i++) begin
         cmd(OP_UPDOWN_CNT, 4'b0000, 12'h005);
         cmd(OP_UPDOWN_CNT, {ud_in[i], 2'b00}, 12'h005);
         cs("updown step", 1'b1, 12'h005, ud_pv[i], ud_f[7 - i]);
      end
      cmd(OP_UPDOWN_CNT, 4'b0000, 12'h005);
      cmd(OP_UPDOWN_CNT, 4'b0110, 12'h005);
      cs("updown reset", 1'b1, 12'h005, 16'h0000, 1'b0);
      cs("counter kept", 1'b1, 12'h001, 16'h0002, 1'b0);
      chk("bus hangs", 32'h0, 32'(ctl.hangs));
      stop_test();
   end
endmodule : testbench
`default_nettype wire
